// >>> src/gxr_ext_regs.sv
// indexed graphics extension register bank with dram, pin and aux port controls
`timescale 1ns/100ps
module gxr_ext_regs
    import gxr_pkg::*;
(
    input  wire logic        sys_clk,            // 200 MHz memory clock
    input  wire logic        reset,              // sync reset, active high
    input  wire logic        clk_en,             // freeze all state when low
    input  wire logic [7:0]  gfx_index,          // graphics index register value
    input  wire logic        data_wr,            // write strobe on data port
    input  wire logic        data_rd,            // read strobe on data port
    input  wire logic [7:0]  data_wdata,         // write data
    output logic      [7:0]  data_rdata,         // registered read data
    output logic             data_hit,           // index belongs to this bank
    input  wire logic [9:0]  line_count,         // live vertical line counter
    input  wire logic        vport_enable,       // video port enabled
    input  wire logic        vport_irq_pend,     // raw video port interrupt
    input  wire logic        vport_irq_src_en,   // video_port_irq_control enable
    input  wire logic        irq_cond,           // internal interrupt condition
    input  wire logic        feature_input_strap, // pin, high when pulled down
    input  wire logic        irq_claim_strap,    // pin, high when pulled down
    input  wire logic        extended_ras_strap, // pin, high when pulled down
    input  wire logic        refresh_count_control, // five refreshes when high, unless GXR_DT_SINGLE is set
    output logic             prog_out_one_pin,   // programmable output 1
    output logic             prog_out_zero_pin,  // programmable output 0
    output logic             video_out_oe,       // pixel/clock/blank/select enable
    output logic             interrupt_gate_n,   // interrupt pin drive low
    output logic             interrupt_gate_oe,  // interrupt pin enable
    output logic             dram_pins_oe,       // dram pin drivers enable
    output gxr_dram_cfg_t    dram_cfg,           // decoded dram timing
    input  wire logic        aux_start,          // start an aux port cycle
    input  wire logic        aux_is_write,       // aux cycle is a write
    input  wire logic        aux_ready_pin,      // peripheral ready pin
    input  wire logic        aux_data_acknowledge, // peripheral acknowledge pin
    output gxr_aux_pins_t    aux_pins,           // aux port strobes
    output logic             aux_busy,           // aux cycle running
    output logic             aux_done            // aux cycle ended
);

    logic [7:0] sl_ff;
    logic [7:0] dt_ff;
    logic [7:0] aux_ff;
    logic [7:0] scr_a_ff;
    logic [7:0] scr_b_ff;
    logic       strap_loaded_ff;
    logic [2:0] strap_fill_ff;
    logic [2:0] feat_sync_ff;
    logic [2:0] claim_sync_ff;
    logic [2:0] eras_sync_ff;
    logic [1:0] rdy_sync_ff;
    logic [1:0] ack_sync_ff;
    logic [7:0] nxt_rdata;

    // index decode shared by read and write paths
    function automatic logic gxr_sel(input logic [7:0] idx, input logic [7:0] want);
        gxr_sel = (idx == want);
    endfunction : gxr_sel

    // masked write, reserved bits kept zero
    function automatic logic [7:0] gxr_wr(input logic [7:0] old, input logic [7:0] val,
                                          input logic [7:0] mask);
        gxr_wr = (old & ~mask) | (val & mask);
    endfunction : gxr_wr

    // read-to-write gap, with edo adding one
    function automatic logic [2:0] gxr_gap(input logic [2:0] base, input logic fast,
                                           input logic edo);
        gxr_gap = base - {2'b00, fast} + {2'b00, edo};
    endfunction : gxr_gap

    wire logic feat_bit = sl_ff[GXR_SL_FEAT];
    wire logic edo_on   = dt_ff[GXR_DT_EDO] & eras_sync_ff[2];

    // two-stage synchronisers for aux pins, three-stage for straps; stage 0 feeds only stage 1
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            feat_sync_ff  <= 3'h0;
            claim_sync_ff <= 3'h0;
            eras_sync_ff  <= 3'h0;
            rdy_sync_ff   <= 2'h0;
            ack_sync_ff   <= 2'h0;
            strap_fill_ff <= 3'h0;
        end
        else if (clk_en)
        begin
            feat_sync_ff  <= {feat_sync_ff[1:0], feature_input_strap};
            claim_sync_ff <= {claim_sync_ff[1:0], irq_claim_strap};
            eras_sync_ff  <= {eras_sync_ff[1:0], extended_ras_strap};
            rdy_sync_ff   <= {rdy_sync_ff[0], aux_ready_pin};
            ack_sync_ff   <= {ack_sync_ff[0], aux_data_acknowledge};
            // marks stages as holding real pin samples, not reset zeros
            strap_fill_ff <= {strap_fill_ff[1:0], 1'b1};
        end
    end

    // scanline high / misc register: writable bits 6, 5, 2 and strap-loaded bit 3
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sl_ff           <= GXR_RESET_ZERO;
            strap_loaded_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!strap_loaded_ff && strap_fill_ff[2] && feat_sync_ff[2] == feat_sync_ff[1])
            begin
                sl_ff[GXR_SL_FEAT] <= feat_sync_ff[2];
                strap_loaded_ff    <= 1'b1;
            end
            else if (data_wr && gxr_sel(gfx_index, GXR_IDX_SCANLINE_HI))
                sl_ff <= gxr_wr(sl_ff, data_wdata, GXR_SL_WMASK);
        end
    end

    // dram timing, aux config and scratch registers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            dt_ff    <= GXR_RESET_ZERO;
            aux_ff   <= GXR_AUX_RESET;
            scr_a_ff <= GXR_RESET_ZERO;
            scr_b_ff <= GXR_RESET_ZERO;
        end
        else if (clk_en && data_wr)
        begin
            if (gxr_sel(gfx_index, GXR_IDX_DRAM_TIMING))
                dt_ff <= gxr_wr(dt_ff, data_wdata, GXR_DT_WMASK);
            if (gxr_sel(gfx_index, GXR_IDX_AUX_CONFIG))
                aux_ff <= gxr_wr(aux_ff, data_wdata, GXR_AUX_WMASK);
            if (gxr_sel(gfx_index, GXR_IDX_SCRATCH_A))
                scr_a_ff <= data_wdata;
            if (gxr_sel(gfx_index, GXR_IDX_SCRATCH_B))
                scr_b_ff <= data_wdata;
        end
    end

    // read mux; line and video port irq bits sampled live at the read, feature bit latched
    always_comb
    begin
        nxt_rdata = GXR_RESET_ZERO;
        if (gxr_sel(gfx_index, GXR_IDX_SCANLINE_HI))
        begin
            nxt_rdata = sl_ff & GXR_SL_WMASK;
            nxt_rdata[GXR_SL_FEAT]  = feat_bit;
            nxt_rdata[GXR_SL_VPIRQ] = vport_irq_pend & vport_irq_src_en;
            nxt_rdata[GXR_SL_LINE_HI -: 2] = line_count[9:8];
        end
        else if (gxr_sel(gfx_index, GXR_IDX_DRAM_TIMING))
            nxt_rdata = dt_ff;
        else if (gxr_sel(gfx_index, GXR_IDX_AUX_CONFIG))
            nxt_rdata = aux_ff;
        else if (gxr_sel(gfx_index, GXR_IDX_SCRATCH_A))
            nxt_rdata = scr_a_ff;
        else if (gxr_sel(gfx_index, GXR_IDX_SCRATCH_B))
            nxt_rdata = scr_b_ff;
    end

    // registered read answer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            data_rdata <= GXR_RESET_ZERO;
            data_hit   <= 1'b0;
        end
        else if (clk_en)
        begin
            data_hit <= (gfx_index >= GXR_IDX_SCANLINE_HI) && (gfx_index <= GXR_IDX_SCRATCH_B);
            if (data_rd)
                data_rdata <= nxt_rdata;
        end
    end

    // pin controls
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            prog_out_one_pin  <= 1'b0;
            prog_out_zero_pin <= 1'b0;
            video_out_oe      <= 1'b0;
            interrupt_gate_n  <= 1'b1;
            interrupt_gate_oe <= 1'b0;
            dram_pins_oe      <= 1'b0;
        end
        else if (clk_en)
        begin
            prog_out_one_pin  <= vport_enable & sl_ff[GXR_SL_OUT1];
            prog_out_zero_pin <= vport_enable & sl_ff[GXR_SL_OUT0];
            video_out_oe      <= strap_loaded_ff & ~feat_bit;
            interrupt_gate_n  <= 1'b0;
            interrupt_gate_oe <= claim_sync_ff[2] & sl_ff[GXR_SL_IRQEN] & irq_cond;
            dram_pins_oe      <= ~dt_ff[GXR_DT_TRIST];
        end
    end

    // decoded timing for the dram sequencer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            dram_cfg <= '0;
        else if (clk_en)
        begin
            dram_cfg.wr_after_rd_gap <= gxr_gap(GXR_WR_GAP_SLOW, dt_ff[GXR_DT_FASTWR],
                                                edo_on);
            dram_cfg.we_after_rd_dly <= gxr_gap(GXR_WE_DLY_SLOW, dt_ff[GXR_DT_FASTWE],
                                                edo_on);
            dram_cfg.refresh_per_line <= dt_ff[GXR_DT_SINGLE] ? GXR_REFR_ONE :
                (refresh_count_control ? GXR_REFR_FIVE : GXR_REFR_THREE);
            dram_cfg.edo_mode      <= edo_on;
            dram_cfg.blt_extra_clk <= edo_on;
            dram_cfg.dram_tristate <= dt_ff[GXR_DT_TRIST];
            dram_cfg.pix16_enable  <= dt_ff[GXR_DT_PIX16];
            dram_cfg.interp_enable <= dt_ff[GXR_DT_INTERP] & dt_ff[GXR_DT_PIX16];
        end
    end

    // aux port cycle engine
    gxr_aux_cycle u_aux
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .cfg      (aux_ff),
        .start    (aux_start),
        .is_write (aux_is_write),
        .ready_s  (rdy_sync_ff[1]),
        .ack_s    (ack_sync_ff[1]),
        .pins     (aux_pins),
        .busy     (aux_busy),
        .done     (aux_done)
    );

endmodule : gxr_ext_regs

// >>> src/gxr_pkg.sv
// package: register indices, field positions, reset values and timing for the extension bank
package gxr_pkg;

    // register indices
    localparam logic [7:0] GXR_IDX_SCANLINE_HI = 8'h17;
    localparam logic [7:0] GXR_IDX_DRAM_TIMING = 8'h18;
    localparam logic [7:0] GXR_IDX_AUX_CONFIG  = 8'h19;
    localparam logic [7:0] GXR_IDX_SCRATCH_A   = 8'h1a;
    localparam logic [7:0] GXR_IDX_SCRATCH_B   = 8'h1b;

    // scanline_hi_and_misc_status field positions
    localparam int GXR_SL_OUT1   = 6;
    localparam int GXR_SL_OUT0   = 5;
    localparam int GXR_SL_VPIRQ  = 4;
    localparam int GXR_SL_FEAT   = 3;
    localparam int GXR_SL_IRQEN  = 2;
    localparam int GXR_SL_LINE_HI = 1;

    // writable masks and reset values; reserved bits read zero
    localparam logic [7:0] GXR_SL_WMASK   = 8'h64;
    localparam logic [7:0] GXR_DT_WMASK   = 8'h7f;
    localparam logic [7:0] GXR_AUX_WMASK  = 8'h3f;
    localparam logic [7:0] GXR_RESET_ZERO = 8'h00;
    localparam logic [7:0] GXR_AUX_RESET  = 8'h00;

    // dram_timing_control field positions
    localparam int GXR_DT_PIX16  = 6;
    localparam int GXR_DT_INTERP = 5;
    localparam int GXR_DT_TRIST  = 4;
    localparam int GXR_DT_SINGLE = 3;
    localparam int GXR_DT_EDO    = 2;
    localparam int GXR_DT_FASTWR = 1;
    localparam int GXR_DT_FASTWE = 0;

    // aux_port_cycle_config field positions
    localparam int GXR_AUX_LONGSTB = 5;
    localparam int GXR_AUX_CS2STB  = 4;
    localparam int GXR_AUX_STB2RDY = 3;
    localparam int GXR_AUX_ADR2CS  = 2;
    localparam int GXR_AUX_ACKEND  = 1;
    localparam int GXR_AUX_WIDE    = 0;

    // memory clock counts and refreshes per line
    localparam logic [2:0] GXR_WR_GAP_SLOW  = 3'h3;
    localparam logic [2:0] GXR_WE_DLY_SLOW  = 3'h2;
    localparam logic [2:0] GXR_ONE_CLK      = 3'h1;
    localparam logic [2:0] GXR_TWO_CLK      = 3'h2;
    localparam logic [2:0] GXR_STB_MIN_S    = 3'h2;
    localparam logic [2:0] GXR_STB_MIN_L    = 3'h4;
    localparam logic [2:0] GXR_REFR_ONE     = 3'h1;
    localparam logic [2:0] GXR_REFR_THREE   = 3'h3;
    localparam logic [2:0] GXR_REFR_FIVE    = 3'h5;

    // decoded timing bundle for the dram sequencer
    typedef struct packed {
        logic [2:0] wr_after_rd_gap;
        logic [2:0] we_after_rd_dly;
        logic [2:0] refresh_per_line;
        logic       edo_mode;
        logic       blt_extra_clk;
        logic       dram_tristate;
        logic       pix16_enable;
        logic       interp_enable;
    } gxr_dram_cfg_t;

    // aux port strobe bundle
    typedef struct packed {
        logic addr_valid;
        logic chip_sel;
        logic read_stb;
        logic write_stb;
        logic wide_bus;
    } gxr_aux_pins_t;

endpackage : gxr_pkg

// >>> src/gxr_aux_cycle.sv
// auxiliary port cycle sequencer driven by aux_port_cycle_config
`timescale 1ns/100ps
module gxr_aux_cycle
    import gxr_pkg::*;
(
    input  wire logic        sys_clk,      // memory clock
    input  wire logic        reset,        // sync reset
    input  wire logic        clk_en,       // freeze when low
    input  wire logic [7:0]  cfg,          // aux_port_cycle_config
    input  wire logic        start,        // begin one cycle
    input  wire logic        is_write,     // write cycle when high
    input  wire logic        ready_s,      // synchronised ready
    input  wire logic        ack_s,        // synchronised acknowledge
    output gxr_aux_pins_t    pins,         // registered strobes
    output logic             busy,         // cycle in progress
    output logic             done          // one-cycle end pulse
);

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CS, ST_STB, ST_END} gxr_aux_st_t;

    gxr_aux_st_t state_ff;
    logic [2:0]  cnt_ff;
    logic [2:0]  stb_cnt_ff;
    logic        wr_ff;
    logic        ack_d_ff;

    // pick one or two clocks from a config bit
    function automatic logic [2:0] gxr_dly(input logic sel);
        gxr_dly = sel ? GXR_TWO_CLK : GXR_ONE_CLK;
    endfunction : gxr_dly

    wire logic       ack_rise   = ack_s & ~ack_d_ff;
    wire logic [2:0] stb_min    = cfg[GXR_AUX_LONGSTB] ? GXR_STB_MIN_L : GXR_STB_MIN_S;
    wire logic       term_seen  = cfg[GXR_AUX_ACKEND] ? ack_rise : ready_s;

    // sequencer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= 3'h0;
            stb_cnt_ff <= 3'h0;
            wr_ff      <= 1'b0;
            ack_d_ff   <= 1'b0;
            pins       <= '0;
            busy       <= 1'b0;
            done       <= 1'b0;
        end
        else if (clk_en)
        begin
            ack_d_ff   <= ack_s;
            done       <= 1'b0;
            pins.wide_bus <= cfg[GXR_AUX_WIDE];
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        wr_ff           <= is_write;
                        pins.addr_valid <= 1'b1;
                        busy            <= 1'b1;
                        cnt_ff          <= gxr_dly(cfg[GXR_AUX_ADR2CS]);
                        state_ff        <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    if (cnt_ff == GXR_ONE_CLK)
                    begin
                        pins.chip_sel <= 1'b1;
                        cnt_ff        <= gxr_dly(cfg[GXR_AUX_CS2STB]);
                        state_ff      <= ST_CS;
                    end
                    else
                        cnt_ff <= cnt_ff - GXR_ONE_CLK;
                end
                ST_CS:
                begin
                    if (cnt_ff == GXR_ONE_CLK)
                    begin
                        pins.read_stb  <= ~wr_ff;
                        pins.write_stb <= wr_ff;
                        cnt_ff         <= gxr_dly(cfg[GXR_AUX_STB2RDY]);
                        stb_cnt_ff     <= GXR_ONE_CLK;
                        state_ff       <= ST_STB;
                    end
                    else
                        cnt_ff <= cnt_ff - GXR_ONE_CLK;
                end
                ST_STB:
                begin
                    if (stb_cnt_ff != stb_min)
                        stb_cnt_ff <= stb_cnt_ff + GXR_ONE_CLK;
                    if (cnt_ff != GXR_ONE_CLK)
                        cnt_ff <= cnt_ff - GXR_ONE_CLK;
                    else if (term_seen && stb_cnt_ff == stb_min)
                    begin
                        pins.read_stb  <= 1'b0;
                        pins.write_stb <= 1'b0;
                        pins.chip_sel  <= 1'b0;
                        state_ff       <= ST_END;
                    end
                end
                ST_END:
                begin
                    pins.addr_valid <= 1'b0;
                    busy            <= 1'b0;
                    done            <= 1'b1;
                    state_ff        <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : gxr_aux_cycle

// >>> dv/gxr_ext_regs_monitor.sv
// checker for the extension register bank ports
`timescale 1ns/100ps
module gxr_ext_regs_monitor
    import gxr_pkg::*;
(
    input wire logic          sys_clk,               // clock
    input wire logic          reset,                 // sync reset
    input wire logic [7:0]    gfx_index,             // index
    input wire logic          data_rd,               // read strobe
    input wire logic [7:0]    data_rdata,            // read data
    input wire logic          vport_enable,          // video port on
    input wire logic          irq_cond,              // interrupt cause
    input wire logic          refresh_count_control, // five refreshes unless GXR_DT_SINGLE set
    input wire logic          prog_out_one_pin,      // output 1
    input wire logic          prog_out_zero_pin,     // output 0
    input wire logic          interrupt_gate_n,      // pin level
    input wire logic          interrupt_gate_oe,     // pin enable
    input wire logic          dram_pins_oe,          // dram drivers
    input wire gxr_dram_cfg_t dram_cfg,              // dram timing
    input wire gxr_aux_pins_t aux_pins,              // aux strobes
    input wire logic          aux_busy,              // aux running
    input wire logic          aux_done               // aux end
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // aux cycle steps
    sequence s_cs_up;
        $rose(aux_pins.chip_sel);
    endsequence
    sequence s_stb_up;
        $rose(aux_pins.read_stb || aux_pins.write_stb);
    endsequence

    a_rd_foreign: assert property (data_rd && !(gfx_index inside {[8'h17:8'h1b]})
        |=> data_rdata == 8'h00) else $error("foreign index read not zero");
    a_prog_gate: assert property ((prog_out_one_pin || prog_out_zero_pin)
        |-> $past(vport_enable)) else $error("output without video port");
    a_irq_cause: assert property (interrupt_gate_oe |-> $past(irq_cond))
        else $error("interrupt driven without cause");
    a_gate_low: assert property (!$past(reset) |-> !interrupt_gate_n)
        else $error("interrupt level not low");
    a_refresh_sel: assert property (!$past(reset)
        && dram_cfg.refresh_per_line != 3'h1
        |-> dram_cfg.refresh_per_line == ($past(refresh_count_control) ? 3'h5 : 3'h3))
        else $error("refresh count wrong");
    a_tristate_oe: assert property (!$past(reset)
        |-> dram_pins_oe == !dram_cfg.dram_tristate)
        else $error("dram enable not opposite tristate");
    a_gap_range: assert property (!$past(reset)
        |-> 3'(dram_cfg.wr_after_rd_gap - dram_cfg.edo_mode) inside {3'h2, 3'h3})
        else $error("write gap out of range");
    a_interp_wide: assert property (dram_cfg.interp_enable
        |-> dram_cfg.pix16_enable) else $error("interpolation without wide bus");
    a_cs_after_addr: assert property (s_cs_up |-> $past(aux_pins.addr_valid))
        else $error("select before address");
    a_strobe_hold: assert property (s_stb_up |-> $past(aux_pins.chip_sel) ##0
        (aux_pins.read_stb || aux_pins.write_stb) [*2]) else $error("strobe too short");
    a_done_end: assert property (aux_done |-> !aux_busy && $past(aux_busy))
        else $error("done without cycle");
endmodule : gxr_ext_regs_monitor

bind gxr_ext_regs gxr_ext_regs_monitor u_mon (.*);

// >>> dv/gxr_aux_peer.sv
// peripheral model for the aux port, answering strobes by ready or acknowledge
`timescale 1ns/100ps
module gxr_aux_peer
    import gxr_pkg::*;
(
    input  wire logic          sys_clk,              // memory clock
    input  wire gxr_aux_pins_t aux_pins,             // strobes from port
    input  wire logic          ack_mode,             // answer by edge
    input  wire logic [3:0]    peer_lag,             // answer delay
    output logic               aux_ready_pin,        // ready back
    output logic               aux_data_acknowledge  // acknowledge back
);
    logic [3:0] wait_ff = 4'h0;

    // count strobe cycles, cleared when idle
    always @(posedge sys_clk)
    begin
        if (!(aux_pins.read_stb || aux_pins.write_stb))
            wait_ff <= 4'h0;
        else if (wait_ff != 4'hf)
            wait_ff <= wait_ff + 4'h1;
    end

    // ready level or acknowledge edge, both low again one clock after a strobe ends
    assign aux_ready_pin        = !ack_mode && (wait_ff > peer_lag);
    assign aux_data_acknowledge = ack_mode && (wait_ff > peer_lag);
endmodule : gxr_aux_peer

// >>> dv/test_gxr_ext_regs.sv
// self-checking bench for the extension register bank
`timescale 1ns/100ps
module test_gxr_ext_regs
    import gxr_pkg::*;
;
    logic          sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, ack_mode = 1'b0;
    logic          data_wr = 1'b0, data_rd = 1'b0, data_hit;
    logic [7:0]    gfx_index = 8'h00, data_wdata = 8'h00, data_rdata, v, f;
    logic [2:0]    g, w, r;
    logic [9:0]    line_count = 10'h2c5;
    logic          vport_enable = 1'b0, vport_irq_pend = 1'b1, vport_irq_src_en = 1'b1;
    logic          irq_cond = 1'b1, feature_input_strap = 1'b1, irq_claim_strap = 1'b1;
    logic          extended_ras_strap = 1'b1, refresh_count_control = 1'b0;
    logic          prog_out_one_pin, prog_out_zero_pin, video_out_oe;
    logic          interrupt_gate_n, interrupt_gate_oe, dram_pins_oe;
    logic          aux_start = 1'b0, aux_is_write = 1'b0, aux_ready_pin;
    logic          aux_data_acknowledge, aux_busy, aux_done;
    logic [3:0]    peer_lag = 4'h1;
    gxr_dram_cfg_t dram_cfg;
    gxr_aux_pins_t aux_pins;
    int            err_count = 0, checked = 0;
    logic [7:0]    ri [4] = '{GXR_IDX_DRAM_TIMING, GXR_IDX_AUX_CONFIG,
                              GXR_IDX_SCRATCH_A, GXR_IDX_SCRATCH_B};
    logic [7:0]    rm [4] = '{8'h7f, 8'h3f, 8'hff, 8'hff};
    logic [7:0]    dv [6] = '{8'h00, 8'h62, 8'h07, 8'h09, 8'h14, 8'h20};
    logic [7:0]    ac [4] = '{8'h00, 8'h3d, 8'h02, 8'h3f};

    gxr_ext_regs u_dut (.*);
    gxr_aux_peer u_peer (.*);

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(negedge sys_clk);
        gfx_index = idx;
        data_wdata = d;
        data_wr = 1'b1;
        @(negedge sys_clk);
        data_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [7:0] q);
        @(negedge sys_clk);
        gfx_index = idx;
        data_rd = 1'b1;
        @(negedge sys_clk);
        data_rd = 1'b0;
        q = data_rdata;
    endtask : rd

    // one aux cycle, timing measured at falling edges
    task automatic aux_run(input logic [7:0] c, input logic wv);
        int ta = -1, tc = -1, ts = -1, te = -1;
        logic wb = 1'b0;
        wr(GXR_IDX_AUX_CONFIG, c);
        ack_mode = c[1];
        @(negedge sys_clk);
        aux_is_write = wv;
        aux_start = 1'b1;
        @(negedge sys_clk);
        aux_start = 1'b0;
        for (int n = 0; n < 100 && !aux_done; n++)
        begin
            if (aux_pins.addr_valid && ta < 0) ta = n;
            if (aux_pins.chip_sel && tc < 0) tc = n;
            if ((aux_pins.read_stb || aux_pins.write_stb) && ts < 0)
            begin
                ts = n;
                wb = aux_pins.wide_bus;
            end
            if (ts >= 0 && te < 0 && !(aux_pins.read_stb || aux_pins.write_stb)) te = n;
            @(negedge sys_clk);
        end
        chk({7'h0, aux_done}, 8'h01);
        chk(8'(tc - ta), c[2] ? 8'h02 : 8'h01);
        chk(8'(ts - tc), c[4] ? 8'h02 : 8'h01);
        chk({7'h0, te - ts >= (c[5] ? 4 : 2)}, 8'h01);
        chk({7'h0, wb}, {7'h0, c[0]});
    endtask : aux_run

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        test_done();
    end

    // main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk) reset = 1'b0;
        repeat (8) @(negedge sys_clk);
        rd(GXR_IDX_SCANLINE_HI, v);
        chk(v, 8'h1a);
        chk({7'h0, video_out_oe}, 8'h00);
        chk({7'h0, data_hit}, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            rd(ri[i], v);
            chk(v, 8'h00);
            wr(ri[i], 8'hff);
            rd(ri[i], v);
            chk(v, rm[i]);
        end
        wr(8'h20, 8'hff);
        rd(8'h20, v);
        chk(v, 8'h00);
        chk({7'h0, data_hit}, 8'h00);
        clk_en = 1'b0;
        wr(GXR_IDX_SCRATCH_A, 8'h5a);
        clk_en = 1'b1;
        rd(GXR_IDX_SCRATCH_A, v);
        chk(v, 8'hff);
        $display("register test over");
        wr(GXR_IDX_SCANLINE_HI, 8'hff);
        rd(GXR_IDX_SCANLINE_HI, v);
        chk(v, 8'h7e);
        vport_enable = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({6'h0, prog_out_one_pin, prog_out_zero_pin}, 8'h03);
        chk({6'h0, interrupt_gate_oe, interrupt_gate_n}, 8'h02);
        vport_enable = 1'b0;
        irq_cond = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk({6'h0, prog_out_one_pin, prog_out_zero_pin}, 8'h00);
        chk({7'h0, interrupt_gate_oe}, 8'h00);
        irq_cond = 1'b1;
        wr(GXR_IDX_SCANLINE_HI, 8'h00);
        repeat (3) @(negedge sys_clk);
        chk({7'h0, interrupt_gate_oe}, 8'h00);
        $display("pin test over");
        wr(GXR_IDX_AUX_CONFIG, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            refresh_count_control = i[0];
            v = dv[i];
            wr(GXR_IDX_DRAM_TIMING, v);
            repeat (3) @(negedge sys_clk);
            g = 3'h3 - v[1] + v[2];
            w = 3'h2 - v[0] + v[2];
            r = v[3] ? 3'h1 : (i[0] ? 3'h5 : 3'h3);
            f = {2'h0, !v[4], v[2], v[2], v[4], v[6], v[5] & v[6]};
            chk({dram_cfg.wr_after_rd_gap, dram_cfg.we_after_rd_dly, 2'h0}, {g, w, 2'h0});
            chk({5'h0, dram_cfg.refresh_per_line}, {5'h0, r});
            chk({2'h0, dram_pins_oe, dram_cfg[4:0]}, f);
        end
        $display("dram test over");
        for (int i = 0; i < 4; i++)
        begin
            peer_lag = i[0] ? 4'h4 : 4'h1;
            aux_run(ac[i], i[0]);
        end
        $display("aux test over");
        reset = 1'b1;
        feature_input_strap = 1'b0;
        irq_claim_strap = 1'b0;
        vport_irq_src_en = 1'b0;
        line_count = 10'h1ff;
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        repeat (8) @(negedge sys_clk);
        rd(GXR_IDX_SCANLINE_HI, v);
        chk(v, 8'h01);
        chk({7'h0, video_out_oe}, 8'h01);
        rd(GXR_IDX_SCRATCH_A, v);
        chk(v, 8'h00);
        wr(GXR_IDX_SCANLINE_HI, 8'h04);
        repeat (3) @(negedge sys_clk);
        chk({7'h0, interrupt_gate_oe}, 8'h00);
        $display("second reset test over");
        test_done();
    end
endmodule : test_gxr_ext_regs
